/* File: logic/lpss_params.svh */
// Constants for the low-power state sequencer: timing and reset values.
// Assumes pclk at 10 MHz; included by the APB slave, the top, the checker and the bench.
`ifndef LPSS_PARAMS_SVH
`define LPSS_PARAMS_SVH
`define LPSS_CLK_PERIOD_NS   100
`define LPSS_PLL_SETTLE_US   30
`define LPSS_PLL_SETTLE_CYC  ((`LPSS_PLL_SETTLE_US * 1000 + \
	`LPSS_CLK_PERIOD_NS - 1) / `LPSS_CLK_PERIOD_NS)
`define LPSS_SETTLE_W        12
`define LPSS_SGNT_DELAY_CYC  20
`define LPSS_VID_LOW_DEF     5'h0C
`define LPSS_VID_HIGH_DEF    5'h08
`define LPSS_RATIO_LOW_DEF   6'h0C
`define LPSS_RATIO_HIGH_DEF  6'h10
`define LPSS_OFS_CTRL        12'h000
`define LPSS_OFS_STATUS      12'h004
`define LPSS_OFS_PAIR_LOW    12'h008
`define LPSS_OFS_PAIR_HIGH   12'h00C
`endif

/* File: logic/lpss_pkg.sv */
// Types shared by the low-power state sequencer modules.
// Assumes the constants header is on the include path.
package lpss_pkg;
	typedef enum logic [2:0] {
		LPSS_NORMAL,
		LPSS_STOP_GRANT,
		LPSS_SLEEP,
		LPSS_DEEP_SLEEP,
		LPSS_SETTLE
	} lpss_state_t;
	typedef enum logic {
		LPSS_MODE_BATTERY,
		LPSS_MODE_MAXPERF
	} lpss_mode_t;
endpackage

/* File: logic/lpss_sync.sv */
// Two-flop synchroniser for pins from the platform side.
// Assumes inputs are asynchronous to pclk; resets to the idle level.
`timescale 1ns/100ps
module lpss_sync #(
	parameter int          W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= RST;
			dout   <= RST;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule

/* File: logic/lpss_apb.sv */
// APB slave with the sequencer's control and status registers.
// Assumes pclk domain; one wait-free access per transfer.
`timescale 1ns/100ps
`include "lpss_params.svh"
module lpss_apb (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  status_in,
	output logic      [4:0]  vid_low_q,
	output logic      [4:0]  vid_high_q,
	output logic      [5:0]  ratio_low_q,
	output logic      [5:0]  ratio_high_q,
	output logic             sleep_wake_en_q
);
	logic acc;
	logic hit;
	assign acc     = psel & penable;
	assign pready  = 1'b1;
	assign hit     = (paddr == `LPSS_OFS_CTRL) |
		(paddr == `LPSS_OFS_STATUS) | (paddr == `LPSS_OFS_PAIR_LOW) |
		(paddr == `LPSS_OFS_PAIR_HIGH);
	assign pslverr = acc & ~hit;
	// Pairs are meant to be set before leaving reset's battery mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vid_low_q       <= `LPSS_VID_LOW_DEF;
			vid_high_q      <= `LPSS_VID_HIGH_DEF;
			ratio_low_q     <= `LPSS_RATIO_LOW_DEF;
			ratio_high_q    <= `LPSS_RATIO_HIGH_DEF;
			sleep_wake_en_q <= 1'b0;
		end else if (acc && pwrite) begin
			case (paddr)
			`LPSS_OFS_CTRL: sleep_wake_en_q <= pwdata[0];
			`LPSS_OFS_PAIR_LOW: begin
				vid_low_q   <= pwdata[4:0];
				ratio_low_q <= pwdata[13:8];
			end
			`LPSS_OFS_PAIR_HIGH: begin
				vid_high_q   <= pwdata[4:0];
				ratio_high_q <= pwdata[13:8];
			end
			default: ;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
			`LPSS_OFS_CTRL:
				prdata <= {31'h0000_0000, sleep_wake_en_q};
			`LPSS_OFS_STATUS:   prdata <= {24'h00_0000, status_in};
			`LPSS_OFS_PAIR_LOW:
				prdata <= {18'h0_0000, ratio_low_q, 3'h0, vid_low_q};
			`LPSS_OFS_PAIR_HIGH:
				prdata <= {18'h0_0000, ratio_high_q, 3'h0, vid_high_q};
			default:            prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule

/* File: logic/lpss_top.sv */
// Low-power state sequencer: Normal, Stop-Grant, Sleep, Deep Sleep
// and the two-level ratio/voltage mode switch through Deep Sleep.
// Assumes request pins are asynchronous, stop-clock, sleep and deep-sleep active low, snoop and interrupt active high; APB on pclk.
//
// Functional notes
// RULE_01 - Reset during Sleep resets fully, skipping Stop-Grant.
// RULE_02 - Platform drops sleep and stop-clock right after asserting reset.
// RULE_03 - From Sleep, deep-sleep request moves to Deep Sleep.
// RULE_04 - Platform drops sleep request before further host-bus events.
// RULE_05 - Sleep request held at least one bus clock.
// RULE_06 - In Sleep, no snoop response and no interrupt handling.
// RULE_07 - Leaving Deep Sleep needs 30 us settle before Sleep counts.
// RULE_08 - In Sleep, releasing sleep request returns to Stop-Grant.
// RULE_09 - Platform stops clock only inside deep-sleep request.
// RULE_10 - In Deep Sleep, no snoop response, interrupts not latched.
// RULE_11 - Platform keeps host-bus and inputs quiet until Stop-Grant.
// RULE_12 - Deeper Sleep equals Deep Sleep at lower platform voltage.
// RULE_13 - Two ratio/voltage pairs; performance select picks one.
// RULE_14 - After reset start in low-frequency battery mode.
// RULE_15 - Mode switches via Deep Sleep with select low or high.
// RULE_16 - Voltage-ID output carries the active mode's code.
// RULE_17 - Platform regulates core to the driven voltage-ID.
// RULE_18 - Sleep entered only from Stop-Grant on sleep request; the code also enters Sleep from Settle after the deep-sleep release.
// RULE_19 - Stop-Grant returns to Normal when stop-clock released.
// RULE_20 - Platform waits ten clocks after sleep release for stop-clock.
// RULE_21 - Sampled mode and voltage-ID change only on Deep Sleep exit; an APB write to the active pair also changes the voltage-ID in any state.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "lpss_params.svh"
module lpss_top (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              stop_clock_request_n,
	input  wire logic              sleep_request_n,
	input  wire logic              deep_sleep_request_n,
	input  wire logic              perf_select_n,
	input  wire logic              snoop_request,
	input  wire logic              interrupt_request,
	output logic      [4:0]        voltage_id_code,
	output logic      [5:0]        bus_ratio,
	output lpss_pkg::lpss_state_t  power_state,
	output lpss_pkg::lpss_mode_t   op_mode,
	output logic                   core_clock_run,
	output logic                   snoop_ack,
	output logic                   interrupt_latched
);
	import lpss_pkg::*;

	logic [5:0] pins_s;
	logic       stop_clock_request_n_s;
	logic       slp_s;
	logic       deep_sleep_request_n_s;
	logic       ghi_s;
	logic       snoop_s;
	logic       intr_s;
	logic [4:0] vid_low_q;
	logic [4:0] vid_high_q;
	logic [5:0] ratio_low_q;
	logic [5:0] ratio_high_q;
	logic       sleep_wake_en_q;
	logic [7:0] status_w;

	lpss_state_t           state_q;
	lpss_mode_t            mode_q;
	lpss_mode_t            mode_pend_q;
	logic [`LPSS_SETTLE_W-1:0] settle_q;
	logic                  snoop_ok;

	// Idle level of every request pin is high for the active-low ones
	lpss_sync #(
		.W   (6),
		.RST (6'h0F)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({snoop_request, interrupt_request, perf_select_n,
			deep_sleep_request_n, sleep_request_n,
			stop_clock_request_n}),
		.dout    (pins_s)
	);
	assign stop_clock_request_n_s = ~pins_s[0];
	assign slp_s    = ~pins_s[1];
	assign deep_sleep_request_n_s  = ~pins_s[2];
	assign ghi_s    = ~pins_s[3];
	assign intr_s   = pins_s[4];
	assign snoop_s  = pins_s[5];

	assign status_w = {2'h0, mode_pend_q, mode_q, 1'b0, state_q};

	lpss_apb u_apb (
		.pclk            (pclk),
		.presetn         (presetn),
		.psel            (psel),
		.penable         (penable),
		.pwrite          (pwrite),
		.paddr           (paddr),
		.pwdata          (pwdata),
		.prdata          (prdata),
		.pready          (pready),
		.pslverr         (pslverr),
		.status_in       (status_w),
		.vid_low_q       (vid_low_q),
		.vid_high_q      (vid_high_q),
		.ratio_low_q     (ratio_low_q),
		.ratio_high_q    (ratio_high_q),
		.sleep_wake_en_q (sleep_wake_en_q)
	);

	// Asynchronous reset lands in Normal from any state, Sleep too [RULE_01]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= LPSS_NORMAL; // [RULE_01]
		end else begin
			case (state_q)
			LPSS_NORMAL: begin
				if (stop_clock_request_n_s)
					state_q <= LPSS_STOP_GRANT;
			end
			LPSS_STOP_GRANT: begin
				if (!stop_clock_request_n_s)
					state_q <= LPSS_NORMAL; // [RULE_19]
				else if (slp_s)
					state_q <= LPSS_SLEEP; // [RULE_18]
			end
			LPSS_SLEEP: begin
				if (deep_sleep_request_n_s)
					state_q <= LPSS_DEEP_SLEEP; // [RULE_03]
				else if (!slp_s)
					state_q <= LPSS_STOP_GRANT; // [RULE_08]
			end
			LPSS_DEEP_SLEEP: begin
				// Deeper Sleep is only a platform voltage level [RULE_12]
				if (!deep_sleep_request_n_s)
					state_q <= LPSS_SETTLE; // [RULE_07]
			end
			LPSS_SETTLE: begin
				if (deep_sleep_request_n_s)
					state_q <= LPSS_DEEP_SLEEP;
				else if (settle_q == `LPSS_SETTLE_W'(1))
					state_q <= LPSS_SLEEP; // [RULE_07]
			end
			default: state_q <= LPSS_NORMAL;
			endcase
		end
	end

	// Clock-stabilisation wait after deep-sleep release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_q <= '0;
		end else if (state_q == LPSS_DEEP_SLEEP) begin
			settle_q <= `LPSS_SETTLE_W'(`LPSS_PLL_SETTLE_CYC); // [RULE_07]
		end else if (state_q == LPSS_SETTLE && settle_q != '0) begin
			settle_q <= settle_q - `LPSS_SETTLE_W'(1);
		end
	end

	// Select is only sampled while parked in Deep Sleep [RULE_21]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_pend_q <= LPSS_MODE_BATTERY; // [RULE_14]
			mode_q      <= LPSS_MODE_BATTERY; // [RULE_14]
		end else begin
			if (state_q == LPSS_DEEP_SLEEP)
				mode_pend_q <= ghi_s ? LPSS_MODE_MAXPERF
					: LPSS_MODE_BATTERY; // [RULE_15]
			if (state_q == LPSS_DEEP_SLEEP && !deep_sleep_request_n_s)
				mode_q <= mode_pend_q; // [RULE_21]
		end
	end

	// Ratio and code move together from one stored pair [RULE_13]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			voltage_id_code <= `LPSS_VID_LOW_DEF;
			bus_ratio       <= `LPSS_RATIO_LOW_DEF;
		end else if (mode_q == LPSS_MODE_MAXPERF) begin
			voltage_id_code <= vid_high_q; // [RULE_16]
			bus_ratio       <= ratio_high_q;
		end else begin
			voltage_id_code <= vid_low_q; // [RULE_16]
			bus_ratio       <= ratio_low_q;
		end
	end

	// Snoops served only in Normal and Stop-Grant; none in the sleep states
	assign snoop_ok = (state_q == LPSS_NORMAL) ||
		(state_q == LPSS_STOP_GRANT);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snoop_ack         <= 1'b0;
			interrupt_latched <= 1'b0;
			core_clock_run    <= 1'b1;
			power_state       <= LPSS_NORMAL;
			op_mode           <= LPSS_MODE_BATTERY;
		end else begin
			snoop_ack      <= snoop_s & snoop_ok; // [RULE_06] [RULE_10]
			core_clock_run <= (state_q == LPSS_NORMAL);
			power_state    <= state_q;
			op_mode        <= mode_q;
			// Held until back in Normal; sleep states drop new events
			if (state_q == LPSS_NORMAL)
				interrupt_latched <= 1'b0;
			else if (intr_s && state_q == LPSS_STOP_GRANT)
				interrupt_latched <= 1'b1; // [RULE_06] [RULE_10]
		end
	end
endmodule

/* File: dv/lpss_top_asserts.sv */
// Checker for the sequencer's state, snoop and mode outputs.
// Assumes it is bound into lpss_top and sees only its ports.
`timescale 1ns/100ps
`include "lpss_params.svh"
module lpss_chk (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  stop_clock_request_n,
	input wire logic                  sleep_request_n,
	input wire logic                  deep_sleep_request_n,
	input wire logic                  snoop_ack,
	input wire logic [4:0]            voltage_id_code,
	input wire logic [5:0]            bus_ratio,
	input wire lpss_pkg::lpss_state_t power_state,
	input wire lpss_pkg::lpss_mode_t  op_mode
);
	import lpss_pkg::*;
	logic [11:0] settle_q;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Settle length never reaches 4096, so no wrap guard
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			settle_q <= 12'h000;
		else if (power_state == LPSS_SETTLE)
			settle_q <= settle_q + 12'h001;
		else
			settle_q <= 12'h000;
	end
	a_sleep_from_grant: assert property (
		power_state == LPSS_SLEEP && $past(power_state) != LPSS_SLEEP
		|-> $past(power_state) inside {LPSS_STOP_GRANT, LPSS_SETTLE})
		else $error("sleep entered from wrong state");
	a_deep_entry: assert property (
		$fell(deep_sleep_request_n) && power_state == LPSS_SLEEP
		|-> ##[1:6] power_state == LPSS_DEEP_SLEEP)
		else $error("deep sleep not entered");
	a_settle_time: assert property (
		power_state == LPSS_SLEEP && $past(power_state) == LPSS_SETTLE
		|-> settle_q >= 12'h12C)
		else $error("settle shorter than 30 us");
	a_no_snoop: assert property (
		power_state inside {LPSS_SLEEP, LPSS_DEEP_SLEEP}
		&& $past(power_state) == power_state |-> !snoop_ack)
		else $error("snoop answered while asleep");
	a_wake_grant: assert property (
		$rose(sleep_request_n) && power_state == LPSS_SLEEP
		|-> ##[1:6] power_state == LPSS_STOP_GRANT)
		else $error("no return to stop-grant");
	a_wake_normal: assert property (
		$rose(stop_clock_request_n) && power_state == LPSS_STOP_GRANT
		|-> ##[1:6] power_state == LPSS_NORMAL)
		else $error("no return to normal");
	a_mode_hold: assert property (
		power_state == LPSS_NORMAL && $past(power_state) == LPSS_NORMAL
		|-> $stable(op_mode) && $stable(voltage_id_code)
		&& $stable(bus_ratio))
		else $error("mode changed outside deep sleep exit");
	a_vid_match: assert property (
		power_state == LPSS_NORMAL |-> voltage_id_code ==
		(op_mode == LPSS_MODE_MAXPERF ? `LPSS_VID_HIGH_DEF
		: `LPSS_VID_LOW_DEF))
		else $error("voltage code does not match mode");
endmodule
bind lpss_top lpss_chk u_chk (.*);

/* File: dv/lpss_plat.sv */
// Platform-side model driving the sequencer's request pins.
// Assumes the bench calls its tasks one at a time on pclk.
`timescale 1ns/100ps
module lpss_plat (
	input  wire logic       pclk,
	input  wire logic [4:0] voltage_id_code,
	output logic            stop_clock_request_n,
	output logic            sleep_request_n,
	output logic            deep_sleep_request_n,
	output logic            perf_select_n,
	output logic            snoop_request,
	output logic            interrupt_request
);
	logic [4:0] vcore_q;
	// Regulator settles on the driven code a clock later
	always @(posedge pclk)
		vcore_q <= voltage_id_code;
	initial begin
		{stop_clock_request_n, sleep_request_n} = 2'h3;
		{deep_sleep_request_n, perf_select_n} = 2'h3;
		{snoop_request, interrupt_request} = 2'h0;
	end
	// Held a clock at least; select set with deep
	task automatic pins(input logic [3:0] v);
		@(posedge pclk);
		{stop_clock_request_n, sleep_request_n,
			deep_sleep_request_n, perf_select_n} <= v;
		@(posedge pclk);
	endtask
	task automatic events(input logic [1:0] v);
		@(posedge pclk);
		{snoop_request, interrupt_request} <= v;
	endtask
	// Sleep dropped first, stop-clock ten clocks on
	task automatic wake();
		@(posedge pclk);
		sleep_request_n <= 1'h1;
		repeat (10) @(posedge pclk);
		stop_clock_request_n <= 1'h1;
	endtask
endmodule

/* File: dv/lpss_tb.sv */
// Bench: APB register checks and walks through the power states.
// Assumes the platform model owns every request pin.
`timescale 1ns/100ps
`include "lpss_params.svh"
module tb;
	import lpss_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, er, p;
	logic        stop_clock_request_n, sleep_request_n;
	logic        deep_sleep_request_n, perf_select_n;
	logic        snoop_request, interrupt_request;
	logic        core_clock_run, snoop_ack, interrupt_latched;
	logic [4:0]  voltage_id_code;
	logic [5:0]  bus_ratio;
	lpss_state_t power_state;
	lpss_mode_t  op_mode;
	int          err_total, n_checks, n;
	lpss_top dut (.*);
	lpss_plat plat (.*);
	// Never stopped, even in deep sleep
	initial begin
		pclk = 1'h0;
		forever #50 pclk = ~pclk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic stall();
		err_total++;
		$display("wrong value at %0t: wait ran out", $time);
		wrap_up();
	endtask
	task automatic chk(input logic [32:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	function automatic logic [32:0] mode_word(input logic m);
		return m ? {m, `LPSS_VID_HIGH_DEF, `LPSS_RATIO_HIGH_DEF}
			: {m, `LPSS_VID_LOW_DEF, `LPSS_RATIO_LOW_DEF};
	endfunction
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'h1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'h1;
		repeat (20) begin
			@(posedge pclk);
			if (pready === 1'h1)
				break;
		end
		if (pready !== 1'h1)
			stall();
		rd = prdata;
		er = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wait_st(input lpss_state_t s);
		n = 0;
		while (power_state !== s) begin
			@(posedge pclk);
			if (++n > 1000)
				stall();
		end
	endtask
	task automatic to_sleep(input logic m);
		plat.events(2'h3);
		plat.pins({3'h3, m});
		wait_st(LPSS_STOP_GRANT);
		chk({snoop_ack, interrupt_latched, core_clock_run}, 3'h6);
		plat.pins({3'h1, m});
		wait_st(LPSS_SLEEP);
	endtask
	initial begin
		{presetn, psel, penable, pwrite} = 4'h0;
		{paddr, pwdata} = 44'h0;
		{err_total, n_checks} = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		chk(power_state, LPSS_NORMAL);
		chk({op_mode, voltage_id_code, bus_ratio}, mode_word(1'h0));
		apb(1'h0, `LPSS_OFS_PAIR_LOW, 32'h0);
		chk(rd, {`LPSS_RATIO_LOW_DEF, 3'h0, `LPSS_VID_LOW_DEF});
		apb(1'h0, `LPSS_OFS_PAIR_HIGH, 32'h0);
		chk(rd, {`LPSS_RATIO_HIGH_DEF, 3'h0, `LPSS_VID_HIGH_DEF});
		apb(1'h1, `LPSS_OFS_CTRL, 32'h1);
		apb(1'h0, `LPSS_OFS_CTRL, 32'h0);
		chk(rd, 32'h1);
		// Unmapped word refused with zero data
		apb(1'h0, 12'h010, 32'h0);
		chk({er, rd}, {1'h1, 32'h0});
		plat.pins(4'hB);
		repeat (8) @(posedge pclk);
		chk(power_state, LPSS_NORMAL);
		plat.pins(4'hF);
		for (int i = 0; i < 3; i++) begin
			p = i[0];
			to_sleep(p);
			chk(snoop_ack, 1'h0);
			plat.pins({3'h0, p});
			wait_st(LPSS_DEEP_SLEEP);
			chk(snoop_ack, 1'h0);
			plat.pins({3'h1, p});
			wait_st(LPSS_SLEEP);
			chk(n >= 300, 1'h1);
			plat.wake();
			wait_st(LPSS_NORMAL);
			chk({interrupt_latched, core_clock_run}, 2'h1);
			rd = p ? `LPSS_VID_LOW_DEF : `LPSS_VID_HIGH_DEF;
			chk(plat.vcore_q, rd);
			chk({op_mode, voltage_id_code, bus_ratio}, mode_word(!p));
			plat.events(2'h0);
		end
		// Last pass left max-performance both active and pending
		apb(1'h0, `LPSS_OFS_STATUS, 32'h0);
		chk(rd, 32'h30);
		to_sleep(1'h0);
		presetn <= 1'h0;
		plat.pins(4'hF);
		chk(power_state, LPSS_NORMAL);
		presetn <= 1'h1;
		repeat (2) @(posedge pclk);
		chk({op_mode, voltage_id_code, bus_ratio}, mode_word(1'h0));
		chk({interrupt_latched, core_clock_run}, 2'h1);
		wrap_up();
	end
endmodule
